// ===== logic/motor_cfg.svh
// Constants for the motor control unit: message codes, reset values, timing.
// Assumes a single 25 MHz clock; included by its bare name.
`ifndef MOTOR_CFG_SVH
`define MOTOR_CFG_SVH

`define THRESHOLD_RESET      8'h40
`define MSG_SET_THRESHOLD    8'h11
`define MSG_SET_NEUTRAL      8'h12
`define NEUTRAL_DISABLE_BIT  0
`define NEUTRAL_SIM_RESET    1'b1
`define THRESHOLD_BASE_UV    23'd991000
`define THRESHOLD_STEP_UV    15'd13770
`define CLOCK_MHZ            25
`define SETTLE_US            50
`define SETTLE_CYCLES        (`SETTLE_US * `CLOCK_MHZ)
`define SETTLE_WIDTH         11

`endif

// ===== logic/motor_pkg.sv
// Types shared by the motor control unit modules.
// Assumes nothing beyond a SystemVerilog compiler.
package motor_pkg;

	typedef enum logic [1:0] {
		phase_a,
		phase_b,
		phase_c
	} phase_t;

	typedef logic [7:0] code_t;

	// Maps the two select levels onto the sampled phase; both codes with
	// the second select high pick phase C.
	function automatic phase_t select_phase(input logic sel1, input logic sel0);
		phase_t result;
		result = phase_c;
		if (!sel1) begin
			result = sel0 ? phase_b : phase_a;
		end
		return result;
	endfunction

endpackage

// ===== logic/phase_sense.sv
// Back-EMF phase multiplexer and zero-crossing detector.
// Assumes comparator results arrive synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none

module phase_sense (
	input  wire logic          clock,
	input  wire logic          reset,
	input  wire logic          phase_sel0,
	input  wire logic          phase_sel1,
	input  wire logic          neutral_sim_enable,
	input  wire logic [2:0]    above_sim,
	input  wire logic [2:0]    above_ext,
	output motor_pkg::phase_t  sampled_phase,
	output logic               zero_cross_out
);

	motor_pkg::phase_t next_phase;
	logic [2:0]        reference_above;
	logic              next_zero_cross;

	assign next_phase = motor_pkg::select_phase(phase_sel1, phase_sel0);

	// The chosen neutral reference feeds the comparator of each phase.
	assign reference_above = neutral_sim_enable ? above_sim : above_ext; // [R12]
	assign next_zero_cross = reference_above[next_phase];

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sampled_phase <= motor_pkg::phase_a;
		end else begin
			sampled_phase <= next_phase; // [R8]
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			zero_cross_out <= 1'b0;
		end else begin
			zero_cross_out <= next_zero_cross; // [R10]
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	phase_select_a: assert property ( // [R8]
		phase_sel1 |=> sampled_phase == motor_pkg::phase_c)
		else $error("Select high did not pick phase C.");

	cross_follow_a: assert property ( // [R10]
		neutral_sim_enable && !zero_cross_out && above_sim[next_phase]
		|=> $rose(zero_cross_out))
		else $error("Zero-crossing output missed a crossing.");

	neutral_source_a: assert property ( // [R12]
		!neutral_sim_enable |=> zero_cross_out == $past(above_ext[next_phase]))
		else $error("Motor neutral not used while simulator is off.");

endmodule

`default_nettype wire

// ===== logic/motor_control_unit.sv
// Motor control unit: gate drive gating, fault and current-limit output,
// current threshold configuration and back-EMF sensing.
// Assumes the host runs the commutation sequence on the gate inputs and
// sends configuration messages as one-cycle strobes on this clock.
//
// Behaviour
// R1 - Host message sets 8-bit threshold code
// R2 - Threshold code resets to 40H
// R3 - Threshold rises 13.77 mV per code
// R4 - Host waits 50 us after threshold write
// R5 - Limit output ORs trip with fault
// R6 - Current trip never switches drivers off
// R7 - Sense amplifier off while chip disabled
// R8 - Select lines pick the sampled phase
// R9 - Host samples the undriven phase
// R10 - Zero-cross output follows back-EMF crossing
// R11 - Host commutates 30 degrees after crossing
// R12 - Neutral simulator can be switched off
// R13 - Chip disabled forces all drivers low
// R14 - Host charges bootstrap with low sides
// R15 - Host lock drives B low, A/C high
// R16 - Host ramps open loop to minimum speed
// R17 - Host runs closed loop on crossings
// R18 - Host follows disabled to run order
// R19 - Step order sets rotation direction
// R20 - Each state energizes exactly two windings
// R21 - Each driver follows its own input
// R22 - Any fault forces all drivers low
// R23 - Host never drives both sides together
`include "motor_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module motor_control_unit (
	input  wire logic          clock,
	input  wire logic          reset,
	input  wire logic          chip_enable,
	input  wire logic          high_gate_a,
	input  wire logic          high_gate_b,
	input  wire logic          high_gate_c,
	input  wire logic          low_gate_a,
	input  wire logic          low_gate_b,
	input  wire logic          low_gate_c,
	input  wire logic          driver_fault_event,
	input  wire logic          current_trip,
	input  wire logic          msg_valid,
	input  wire logic [7:0]    msg_id,
	input  wire logic [7:0]    msg_data,
	input  wire logic          phase_sel0,
	input  wire logic          phase_sel1,
	input  wire logic [2:0]    above_sim,
	input  wire logic [2:0]    above_ext,
	input  wire logic          limit_fault_n_in,
	output logic               high_drive_a,
	output logic               high_drive_b,
	output logic               high_drive_c,
	output logic               low_drive_a,
	output logic               low_drive_b,
	output logic               low_drive_c,
	output logic               limit_fault_n_out,
	output logic               limit_fault_n_oe,
	output logic               sense_amp_enable,
	output motor_pkg::code_t   threshold_code,
	output logic [22:0]        threshold_uv,
	output logic               threshold_settled,
	output logic               neutral_sim_enable,
	output logic               limit_pin_low,
	output motor_pkg::phase_t  sampled_phase,
	output logic               zero_cross_out
);

	logic                      fault_latched;
	logic                      fault_active;
	logic                      drive_allowed;
	logic                      threshold_write;
	logic                      neutral_write;
	logic [`SETTLE_WIDTH-1:0]  settle_count;
	logic [5:0]                gate_in;
	logic [5:0]                next_drive;

	assign gate_in = {high_gate_a, high_gate_b, high_gate_c, low_gate_a, low_gate_b, low_gate_c};
	assign threshold_write = msg_valid && (msg_id == `MSG_SET_THRESHOLD);
	assign neutral_write   = msg_valid && (msg_id == `MSG_SET_NEUTRAL);

	// A driver fault latches until the chip enable is taken low; a new fault
	// in the same cycle wins over the clear.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			fault_latched <= 1'b0;
		end else if (driver_fault_event) begin
			fault_latched <= 1'b1;
		end else if (!chip_enable) begin
			fault_latched <= 1'b0;
		end
	end

	assign fault_active  = fault_latched || driver_fault_event;
	// The current trip deliberately takes no part in this gating.
	assign drive_allowed = chip_enable && !fault_active; // [R13] [R22] [R6]
	assign next_drive    = drive_allowed ? gate_in : 6'h00; // [R21]

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			high_drive_a <= 1'b0;
			high_drive_b <= 1'b0;
			high_drive_c <= 1'b0;
			low_drive_a  <= 1'b0;
			low_drive_b  <= 1'b0;
			low_drive_c  <= 1'b0;
		end else begin
			high_drive_a <= next_drive[5]; // [R21]
			high_drive_b <= next_drive[4];
			high_drive_c <= next_drive[3];
			low_drive_a  <= next_drive[2];
			low_drive_b  <= next_drive[1];
			low_drive_c  <= next_drive[0];
		end
	end

	// The shared open-drain pin only ever pulls low.
	assign limit_fault_n_out = 1'b0;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			limit_fault_n_oe <= 1'b0;
		end else begin
			limit_fault_n_oe <= current_trip || fault_active; // [R5]
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			limit_pin_low <= 1'b0;
		end else begin
			limit_pin_low <= !limit_fault_n_in;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sense_amp_enable <= 1'b0;
		end else begin
			sense_amp_enable <= chip_enable; // [R7]
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			threshold_code <= `THRESHOLD_RESET; // [R2]
		end else if (threshold_write) begin
			threshold_code <= msg_data; // [R1]
		end
	end

	// Nominal threshold level in microvolts, linear in the code.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			threshold_uv <= `THRESHOLD_BASE_UV + 23'(`THRESHOLD_RESET * `THRESHOLD_STEP_UV);
		end else begin
			threshold_uv <= `THRESHOLD_BASE_UV + 23'(threshold_code * `THRESHOLD_STEP_UV); // [R3]
		end
	end

	// Counts out the reference settling time after each threshold write so
	// the host can see when the new limit is in force.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			settle_count <= '0;
		end else if (threshold_write) begin
			settle_count <= `SETTLE_WIDTH'(`SETTLE_CYCLES); // [R4]
		end else if (settle_count != '0) begin
			settle_count <= settle_count - 1'b1;
		end
	end

	assign threshold_settled = (settle_count == '0);

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			neutral_sim_enable <= `NEUTRAL_SIM_RESET;
		end else if (neutral_write) begin
			neutral_sim_enable <= !msg_data[`NEUTRAL_DISABLE_BIT]; // [R12]
		end
	end

	phase_sense sense (
		.clock              (clock),
		.reset              (reset),
		.phase_sel0         (phase_sel0),
		.phase_sel1         (phase_sel1),
		.neutral_sim_enable (neutral_sim_enable),
		.above_sim          (above_sim),
		.above_ext          (above_ext),
		.sampled_phase      (sampled_phase),
		.zero_cross_out     (zero_cross_out)
	);

	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	sequence threshold_written;
		threshold_write ##1 !threshold_write;
	endsequence

	drives_off_disabled_a: assert property ( // [R13]
		!chip_enable |=> {high_drive_a, high_drive_b, high_drive_c,
		low_drive_a, low_drive_b, low_drive_c} == 6'h00)
		else $error("Drivers active while chip disabled.");

	drives_off_fault_a: assert property ( // [R22]
		driver_fault_event |=> {high_drive_a, high_drive_b, high_drive_c,
		low_drive_a, low_drive_b, low_drive_c} == 6'h00 [*2])
		else $error("Drivers active during a fault.");

	drive_follow_a: assert property ( // [R21]
		chip_enable && !fault_active |=> high_drive_b == $past(high_gate_b)
		&& low_drive_c == $past(low_gate_c))
		else $error("Driver did not follow its input.");

	trip_keeps_drive_a: assert property ( // [R6]
		current_trip && chip_enable && !fault_active
		|=> {high_drive_a, high_drive_b, high_drive_c, low_drive_a, low_drive_b,
		low_drive_c} == $past(gate_in) && limit_fault_n_oe)
		else $error("Current trip changed drivers or missed the pin.");

	limit_or_fault_a: assert property ( // [R5]
		fault_latched && !current_trip |=> limit_fault_n_oe)
		else $error("Fault not shown on the limit pin.");

	amp_off_disabled_a: assert property ( // [R7]
		!chip_enable [*2] |-> !sense_amp_enable)
		else $error("Sense amplifier on while chip disabled.");

	threshold_load_a: assert property ( // [R1]
		threshold_written |-> threshold_code == $past(msg_data))
		else $error("Threshold code not loaded from message.");

	threshold_linear_a: assert property ( // [R3]
		$stable(threshold_code) |=> threshold_uv == `THRESHOLD_BASE_UV
		+ 23'($past(threshold_code) * `THRESHOLD_STEP_UV))
		else $error("Threshold level not linear in the code.");

	settle_window_a: assert property ( // [R4]
		threshold_write |=> !threshold_settled [*8])
		else $error("Settling flag rose too early.");

	threshold_hold_a: assert property ( // [R2]
		!threshold_write |=> $stable(threshold_code))
		else $error("Threshold code changed without a write.");

endmodule

`default_nettype wire

// ===== dv/host_model.sv
// Host side model: plays the commutation sequence onto the gate inputs
// and picks the undriven phase on the selects. Changes only on clock edges.
`timescale 1ns/1ps
`default_nettype none

module host_model (
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic [3:0] step,
	output logic            high_gate_a,
	output logic            high_gate_b,
	output logic            high_gate_c,
	output logic            low_gate_a,
	output logic            low_gate_b,
	output logic            low_gate_c,
	output logic            phase_sel0,
	output logic            phase_sel1
);
	logic [7:0] word;

	assign {high_gate_a, high_gate_b, high_gate_c, low_gate_a, low_gate_b, low_gate_c,
		phase_sel1, phase_sel0} = word;

	// Step 0 disabled, 1 bootstrap, 2 lock, 3 to 8 the six states in forward order.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			word <= 8'h00;
		end else begin
			case (step)
				4'h1: word <= 8'b000111_11;
				4'h2: word <= 8'b101010_00;
				4'h3: word <= 8'b100001_01;
				4'h4: word <= 8'b010001_00;
				4'h5: word <= 8'b010100_10;
				4'h6: word <= 8'b001100_01;
				4'h7: word <= 8'b001010_00;
				4'h8: word <= 8'b100010_10;
				default: word <= 8'h00;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== dv/motor_control_unit_test.sv
// Self-checking bench for the motor control unit with the host model.
// Assumes the open-drain limit pin has a pull-up on the board.
`timescale 1ns/1ps
`default_nettype none

module motor_control_unit_test;
	logic              clock, reset, chip_enable, driver_fault_event, current_trip, msg_valid;
	logic [7:0]        msg_id, msg_data;
	logic [3:0]        step;
	logic [2:0]        above_sim, above_ext;
	logic [1:0]        exp_ph;
	wire logic         high_gate_a, high_gate_b, high_gate_c, low_gate_a, low_gate_b, low_gate_c;
	wire logic         phase_sel0, phase_sel1, limit_fault_n_in;
	logic              high_drive_a, high_drive_b, high_drive_c, low_drive_a, low_drive_b;
	logic              low_drive_c, limit_fault_n_out, limit_fault_n_oe, sense_amp_enable;
	logic              threshold_settled, neutral_sim_enable, limit_pin_low, zero_cross_out;
	logic [22:0]       threshold_uv;
	motor_pkg::code_t  threshold_code;
	motor_pkg::phase_t sampled_phase;
	int                n_errors, num_checks;
	wire logic [5:0]   gates = {high_gate_a, high_gate_b, high_gate_c, low_gate_a, low_gate_b,
		low_gate_c};
	wire logic [5:0]   drives = {high_drive_a, high_drive_b, high_drive_c, low_drive_a,
		low_drive_b, low_drive_c};

	// The pull-up wins whenever the pin is released.
	assign limit_fault_n_in = limit_fault_n_oe ? limit_fault_n_out : 1'b1;

	host_model i_host (.clock, .reset, .step, .high_gate_a, .high_gate_b, .high_gate_c,
		.low_gate_a, .low_gate_b, .low_gate_c, .phase_sel0, .phase_sel1);

	motor_control_unit i_dut (.clock, .reset, .chip_enable, .high_gate_a, .high_gate_b,
		.high_gate_c, .low_gate_a, .low_gate_b, .low_gate_c, .driver_fault_event,
		.current_trip, .msg_valid, .msg_id, .msg_data, .phase_sel0, .phase_sel1, .above_sim,
		.above_ext, .limit_fault_n_in, .high_drive_a, .high_drive_b, .high_drive_c,
		.low_drive_a, .low_drive_b, .low_drive_c, .limit_fault_n_out, .limit_fault_n_oe,
		.sense_amp_enable, .threshold_code, .threshold_uv, .threshold_settled,
		.neutral_sim_enable, .limit_pin_low, .sampled_phase, .zero_cross_out);

	task automatic chk(input logic [22:0] got, input logic [22:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic send(input logic [7:0] id, input logic [7:0] d);
		@(posedge clock);
		msg_valid <= 1'b1;
		msg_id <= id;
		msg_data <= d;
		@(posedge clock);
		msg_valid <= 1'b0;
	endtask

	task automatic end_of_test();
		if (n_errors == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	initial begin
		#(5000 * 40);
		n_errors++;
		end_of_test();
	end

	initial begin
		{reset, chip_enable, driver_fault_event, current_trip, msg_valid} = 5'b10000;
		{msg_id, msg_data, step, above_sim, above_ext} = '0;
		repeat (20) @(posedge clock);
		reset <= 1'b0;
		tick(1);
		chk(threshold_code, 8'h40);
		chk(threshold_uv, 23'd1872280);
		chk(threshold_settled, 1'b1);
		chk(neutral_sim_enable, 1'b1);
		@(posedge clock);
		step <= 4'h1;
		tick(2);
		chk(drives, 6'h00);
		chk(sense_amp_enable, 1'b0);
		@(posedge clock);
		chip_enable <= 1'b1;
		tick(1);
		chk(sense_amp_enable, 1'b1);
		for (int s = 0; s < 9; s++) begin
			@(posedge clock);
			step <= s[3:0];
			tick(1);
			exp_ph = phase_sel1 ? 2'd2 : {1'b0, phase_sel0};
			@(posedge clock);
			above_sim <= 3'b001 << exp_ph;
			tick(1);
			chk(drives, gates);
			chk(sampled_phase, exp_ph);
			chk(zero_cross_out, 1'b1);
			@(posedge clock);
			above_sim <= ~(3'b001 << exp_ph);
			tick(1);
			chk(zero_cross_out, 1'b0);
		end
		@(posedge clock);
		current_trip <= 1'b1;
		tick(1);
		chk(limit_fault_n_oe, 1'b1);
		chk(drives, gates);
		tick(1);
		chk(limit_pin_low, 1'b1);
		chk(limit_fault_n_out, 1'b0);
		@(posedge clock);
		current_trip <= 1'b0;
		tick(1);
		chk(limit_fault_n_oe, 1'b0);
		@(posedge clock);
		driver_fault_event <= 1'b1;
		@(posedge clock);
		driver_fault_event <= 1'b0;
		tick(1);
		chk(drives, 6'h00);
		chk(limit_fault_n_oe, 1'b1);
		@(posedge clock);
		chip_enable <= 1'b0;
		@(posedge clock);
		chip_enable <= 1'b1;
		tick(2);
		chk(drives, gates);
		chk(limit_fault_n_oe, 1'b0);
		send(8'h12, 8'h01);
		tick(1);
		chk(neutral_sim_enable, 1'b0);
		@(posedge clock);
		above_sim <= 3'b000;
		above_ext <= 3'b111;
		tick(1);
		chk(zero_cross_out, 1'b1);
		send(8'h11, 8'h00);
		tick(1);
		chk(threshold_code, 8'h00);
		chk(threshold_settled, 1'b0);
		tick(1);
		chk(threshold_uv, 23'd991000);
		send(8'h33, 8'h55);
		tick(1);
		chk(threshold_code, 8'h00);
		send(8'h11, 8'hFF);
		tick(1249);
		chk(threshold_code, 8'hFF);
		chk(threshold_uv, 23'd4502350);
		chk(threshold_settled, 1'b0);
		tick(2);
		chk(threshold_settled, 1'b1);
		end_of_test();
	end
endmodule
`default_nettype wire
